// ==== common/uart_io_pkg.sv ====
package uart_io_pkg;

    localparam int           CHANNELS       = 8;
    localparam int           WINDOW_BYTES   = 8;
    localparam int           OFFSET_W       = 3;

    // byte offsets inside one channel window
    localparam logic [2:0]   OFS_HOLDING    = 3'h0;
    localparam logic [2:0]   OFS_INT_ENABLE = 3'h1;
    localparam logic [2:0]   OFS_INT_FIFO   = 3'h2;
    localparam logic [2:0]   OFS_LINE_CTRL  = 3'h3;
    localparam logic [2:0]   OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0]   OFS_LINE_STAT  = 3'h5;
    localparam logic [2:0]   OFS_MODEM_STAT = 3'h6;
    localparam logic [2:0]   OFS_SPECIAL    = 3'h7;

    localparam int           DIV_ACCESS_BIT = 7;

    localparam logic [7:0]   RST_REG        = 8'h00;
    localparam logic [7:0]   RST_INT_STATUS = 8'hC1;
    localparam logic [7:0]   RDATA_UNMAPPED = 8'h00;

endpackage : uart_io_pkg

// ==== logic/uart_io_decode.sv ====
`timescale 1ns/1ps

// Summary of operation
// - each channel owns an eight byte window
// - channel n window at base plus n times eight
// - address minus base decodes channel and register
// - offset 0 reads receive, writes transmit holding
// - offset 1 is interrupt enable register
// - offset 2 reads status, writes fifo control
// - offset 3 line control, bit 7 divisor access
// - offset 4 is modem control register
// - offset 5 line status, writes ignored
// - offset 6 modem status, writes ignored
// - offset 7 is special function register
// - divisor access swaps offsets 0 to 2
// - interrupt status resets to C1h, then follows the core
module uart_io_decode #(
    parameter int ADDR_W   = 32,
    parameter int CHANNELS = uart_io_pkg::CHANNELS
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [ADDR_W-1:0]     bar0_base,
    input  wire logic                  io_req,
    input  wire logic                  io_write,
    input  wire logic [ADDR_W-1:0]     io_addr,
    input  wire logic [7:0]            io_wdata,
    output logic                       io_ack,
    output logic                       io_hit,
    output logic [7:0]                 io_rdata,
    input  wire logic [CHANNELS*8-1:0] receive_holding,
    input  wire logic [CHANNELS*8-1:0] interrupt_status_in,
    input  wire logic [CHANNELS*8-1:0] line_status_in,
    input  wire logic [CHANNELS*8-1:0] modem_status_in,
    output logic [CHANNELS-1:0]        rx_read,
    output logic [CHANNELS-1:0]        tx_load,
    output logic [CHANNELS-1:0]        fifo_control_load,
    output logic [7:0]                 write_data,
    output logic [CHANNELS*8-1:0]      interrupt_enable,
    output logic [CHANNELS*8-1:0]      line_control,
    output logic [CHANNELS*8-1:0]      modem_control,
    output logic [CHANNELS*8-1:0]      special_function,
    output logic [CHANNELS*8-1:0]      divisor_low,
    output logic [CHANNELS*8-1:0]      divisor_high,
    output logic [CHANNELS*8-1:0]      sample_clock_select
);

    localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
    localparam int SPAN = CHANNELS * uart_io_pkg::WINDOW_BYTES;

    // stored per-channel registers
    logic [7:0] int_enable      [CHANNELS];
    logic [7:0] line_ctrl       [CHANNELS];
    logic [7:0] modem_ctrl      [CHANNELS];
    logic [7:0] special         [CHANNELS];
    logic [7:0] div_low         [CHANNELS];
    logic [7:0] div_high        [CHANNELS];
    logic [7:0] sample_clk      [CHANNELS];

    // status views copied from the channel cores
    logic [7:0] int_stat        [CHANNELS];
    logic [7:0] line_stat       [CHANNELS];
    logic [7:0] modem_stat      [CHANNELS];

    logic [7:0] next_int_enable [CHANNELS];
    logic [7:0] next_line_ctrl  [CHANNELS];
    logic [7:0] next_modem_ctrl [CHANNELS];
    logic [7:0] next_special    [CHANNELS];
    logic [7:0] next_div_low    [CHANNELS];
    logic [7:0] next_div_high   [CHANNELS];
    logic [7:0] next_sample_clk [CHANNELS];
    logic [7:0] next_int_stat   [CHANNELS];
    logic [7:0] next_line_stat  [CHANNELS];
    logic [7:0] next_modem_stat [CHANNELS];

    // one-hot write strobes, one bit per channel
    logic [CHANNELS-1:0] wr_int_enable;
    logic [CHANNELS-1:0] wr_line_ctrl;
    logic [CHANNELS-1:0] wr_modem_ctrl;
    logic [CHANNELS-1:0] wr_special;
    logic [CHANNELS-1:0] wr_div_low;
    logic [CHANNELS-1:0] wr_div_high;
    logic [CHANNELS-1:0] wr_sample_clk;

    logic                next_ack;
    logic                next_hit;
    logic [7:0]          next_rdata;
    logic [CHANNELS-1:0] next_rx_read;
    logic [CHANNELS-1:0] next_tx_load;
    logic [CHANNELS-1:0] next_fcr_load;
    logic [7:0]          next_write_data;

    logic [ADDR_W-1:0]   rel_addr;
    logic                in_range;
    logic [CH_W-1:0]     chan;
    logic [2:0]          ofs;
    logic                div_access;

    // wraparound below the base makes rel_addr huge, so one compare covers
    // both ends of the window range
    assign rel_addr = io_addr - bar0_base;
    assign in_range = rel_addr < ADDR_W'(SPAN);
    assign chan     = rel_addr[uart_io_pkg::OFFSET_W +: CH_W];
    assign ofs      = rel_addr[uart_io_pkg::OFFSET_W-1:0];
    assign div_access = line_ctrl[chan][uart_io_pkg::DIV_ACCESS_BIT];

    // bus side: decode, answer and strobes
    always_comb begin
        next_ack        = io_req;
        next_hit        = 1'b0;
        next_rdata      = uart_io_pkg::RDATA_UNMAPPED;
        next_rx_read    = '0;
        next_tx_load    = '0;
        next_fcr_load   = '0;
        next_write_data = write_data;
        wr_int_enable   = '0;
        wr_line_ctrl    = '0;
        wr_modem_ctrl   = '0;
        wr_special      = '0;
        wr_div_low      = '0;
        wr_div_high     = '0;
        wr_sample_clk   = '0;
        if (io_req && in_range) begin
            next_hit = 1'b1;
            if (io_write) begin
                next_write_data = io_wdata;
                case (ofs)
                    uart_io_pkg::OFS_HOLDING: begin
                        if (div_access) begin
                            wr_div_low[chan] = 1'b1;
                        end else begin
                            next_tx_load[chan] = 1'b1;
                        end
                    end
                    uart_io_pkg::OFS_INT_ENABLE: begin
                        if (div_access) begin
                            wr_div_high[chan] = 1'b1;
                        end else begin
                            wr_int_enable[chan] = 1'b1;
                        end
                    end
                    uart_io_pkg::OFS_INT_FIFO: begin
                        if (div_access) begin
                            wr_sample_clk[chan] = 1'b1;
                        end else begin
                            next_fcr_load[chan] = 1'b1;
                        end
                    end
                    uart_io_pkg::OFS_LINE_CTRL: begin
                        wr_line_ctrl[chan] = 1'b1;
                    end
                    uart_io_pkg::OFS_MODEM_CTRL: begin
                        wr_modem_ctrl[chan] = 1'b1;
                    end
                    uart_io_pkg::OFS_SPECIAL: begin
                        wr_special[chan] = 1'b1;
                    end
                    // status offsets accept the write and drop it
                    default: begin
                        next_hit = 1'b1;
                    end
                endcase
            end else begin
                case (ofs)
                    uart_io_pkg::OFS_HOLDING: begin
                        if (div_access) begin
                            next_rdata = div_low[chan];
                        end else begin
                            next_rdata = receive_holding[chan*8 +: 8];
                            next_rx_read[chan] = 1'b1;
                        end
                    end
                    uart_io_pkg::OFS_INT_ENABLE: begin
                        next_rdata = div_access ? div_high[chan]
                                                : int_enable[chan];
                    end
                    uart_io_pkg::OFS_INT_FIFO: begin
                        next_rdata = div_access ? sample_clk[chan]
                                                : int_stat[chan];
                    end
                    uart_io_pkg::OFS_LINE_CTRL: begin
                        next_rdata = line_ctrl[chan];
                    end
                    uart_io_pkg::OFS_MODEM_CTRL: begin
                        next_rdata = modem_ctrl[chan];
                    end
                    uart_io_pkg::OFS_LINE_STAT: begin
                        next_rdata = line_stat[chan];
                    end
                    uart_io_pkg::OFS_MODEM_STAT: begin
                        next_rdata = modem_stat[chan];
                    end
                    uart_io_pkg::OFS_SPECIAL: begin
                        next_rdata = special[chan];
                    end
                    default: begin
                        next_rdata = uart_io_pkg::RDATA_UNMAPPED;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            io_ack            <= 1'b0;
            io_hit            <= 1'b0;
            io_rdata          <= uart_io_pkg::RDATA_UNMAPPED;
            rx_read           <= '0;
            tx_load           <= '0;
            fifo_control_load <= '0;
            write_data        <= uart_io_pkg::RST_REG;
        end else begin
            io_ack            <= next_ack;
            io_hit            <= next_hit;
            io_rdata          <= next_rdata;
            rx_read           <= next_rx_read;
            tx_load           <= next_tx_load;
            fifo_control_load <= next_fcr_load;
            write_data        <= next_write_data;
        end
    end

    // channel side: one copy of the register file per channel
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        always_comb begin
            next_int_enable[g] = wr_int_enable[g] ? io_wdata
                                                  : int_enable[g];
            next_line_ctrl[g]  = wr_line_ctrl[g] ? io_wdata
                                                 : line_ctrl[g];
            next_modem_ctrl[g] = wr_modem_ctrl[g] ? io_wdata
                                                  : modem_ctrl[g];
            next_special[g]    = wr_special[g] ? io_wdata
                                               : special[g];
            next_div_low[g]    = wr_div_low[g] ? io_wdata
                                               : div_low[g];
            next_div_high[g]   = wr_div_high[g] ? io_wdata
                                                : div_high[g];
            next_sample_clk[g] = wr_sample_clk[g] ? io_wdata
                                                  : sample_clk[g];
            // status views follow the channel core every cycle, so a read
            // returns the value one cycle old
            next_int_stat[g]   = interrupt_status_in[g*8 +: 8];
            next_line_stat[g]  = line_status_in[g*8 +: 8];
            next_modem_stat[g] = modem_status_in[g*8 +: 8];
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                int_enable[g] <= uart_io_pkg::RST_REG;
                line_ctrl[g]  <= uart_io_pkg::RST_REG;
                modem_ctrl[g] <= uart_io_pkg::RST_REG;
                special[g]    <= uart_io_pkg::RST_REG;
                div_low[g]    <= uart_io_pkg::RST_REG;
                div_high[g]   <= uart_io_pkg::RST_REG;
                sample_clk[g] <= uart_io_pkg::RST_REG;
                int_stat[g]   <= uart_io_pkg::RST_INT_STATUS;
                line_stat[g]  <= uart_io_pkg::RST_REG;
                modem_stat[g] <= uart_io_pkg::RST_REG;
            end else begin
                int_enable[g] <= next_int_enable[g];
                line_ctrl[g]  <= next_line_ctrl[g];
                modem_ctrl[g] <= next_modem_ctrl[g];
                special[g]    <= next_special[g];
                div_low[g]    <= next_div_low[g];
                div_high[g]   <= next_div_high[g];
                sample_clk[g] <= next_sample_clk[g];
                int_stat[g]   <= next_int_stat[g];
                line_stat[g]  <= next_line_stat[g];
                modem_stat[g] <= next_modem_stat[g];
            end
        end

        // flatten the per-channel flops onto the output buses
        assign interrupt_enable[g*8 +: 8]    = int_enable[g];
        assign line_control[g*8 +: 8]        = line_ctrl[g];
        assign modem_control[g*8 +: 8]       = modem_ctrl[g];
        assign special_function[g*8 +: 8]    = special[g];
        assign divisor_low[g*8 +: 8]         = div_low[g];
        assign divisor_high[g*8 +: 8]        = div_high[g];
        assign sample_clock_select[g*8 +: 8] = sample_clk[g];
    end

endmodule : uart_io_decode

// ==== verif/uart_io_decode_props.sv ====
`timescale 1ns/1ps

module uart_io_decode_chk #(
    parameter int ADDR_W   = 32,
    parameter int CHANNELS = 8
) (
    input wire logic                  sys_clk, rst, io_req, io_write,
    input wire logic                  io_ack, io_hit,
    input wire logic [ADDR_W-1:0]     bar0_base, io_addr,
    input wire logic [7:0]            io_wdata, io_rdata, write_data,
    input wire logic [CHANNELS-1:0]   rx_read, tx_load, fifo_control_load,
    input wire logic [CHANNELS*8-1:0] line_control, divisor_low
);
    logic [ADDR_W-1:0] rel;
    logic [2:0]        ch;
    logic              win;
    logic [5:0]        sel;
    assign rel = io_addr - bar0_base;
    assign ch  = rel[5:3];
    assign win = io_req && (rel < ADDR_W'(CHANNELS * 8));
    // hit, direction, divisor access, offset in one code
    assign sel = {win, io_write, line_control[{ch, 3'h7}], rel[2:0]};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_every_req: assert property (io_req |=> io_ack)
        else $error("request not acknowledged");
    a_hit_in_window: assert property (win |=> io_hit)
        else $error("window access missed");
    a_miss_is_silent: assert property (io_req && !win
        |=> !io_hit && io_rdata == 8'h00 && tx_load == '0)
        else $error("miss had an effect");
    a_tx_load_one: assert property (sel == 6'h30
        |=> tx_load == (CHANNELS'(1) << $past(ch))
            && write_data == $past(io_wdata))
        else $error("transmit load wrong");
    a_rx_read_one: assert property (sel == 6'h20 |=> rx_read[$past(ch)])
        else $error("receive read pulse missing");
    a_fifo_load_one: assert property (sel == 6'h32
        |=> fifo_control_load[$past(ch)] && tx_load == '0)
        else $error("fifo control load wrong");
    a_line_ctrl_write: assert property (sel inside {6'h33, 6'h3B}
        |=> line_control[{$past(ch), 3'h0} +: 8] == $past(io_wdata))
        else $error("line control not written");
    a_divisor_write: assert property (sel == 6'h38
        |=> divisor_low[{$past(ch), 3'h0} +: 8] == $past(io_wdata)
            && tx_load == '0)
        else $error("divisor low not written");
endmodule : uart_io_decode_chk

bind uart_io_decode uart_io_decode_chk #(.ADDR_W(ADDR_W), .CHANNELS(CHANNELS))
    u_chk (.sys_clk, .rst, .io_req, .io_write, .io_ack, .io_hit, .bar0_base,
    .io_addr, .io_wdata, .io_rdata, .write_data, .rx_read, .tx_load,
    .fifo_control_load, .line_control, .divisor_low);

// ==== verif/io_host.sv ====
`timescale 1ns/1ps

module io_host (
    input  wire logic        sys_clk,
    input  wire logic        io_ack,
    input  wire logic        io_hit,
    input  wire logic [7:0]  io_rdata,
    output logic             io_req = 1'b0,
    output logic             io_write = 1'b0,
    output logic [31:0]      io_addr = 32'h0,
    output logic [7:0]       io_wdata = 8'h00
);
    logic timed_out = 1'b0;

    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [7:0] d, output logic [7:0] rd,
                        output logic hit);
        @(negedge sys_clk);
        io_req = 1'b1;
        io_write = w;
        io_addr = a;
        io_wdata = d;
        @(negedge sys_clk);
        io_req = 1'b0;
        // released lines must not keep showing the old value
        io_write = ~w;
        io_addr = ~a;
        io_wdata = ~d;
        for (int n = 0; n < 4 && io_ack !== 1'b1; n++) @(negedge sys_clk);
        timed_out = (io_ack !== 1'b1);
        rd = io_rdata;
        hit = io_hit;
    endtask : xfer
endmodule : io_host

// ==== verif/testbench.sv ====
`timescale 1ns/1ps

module testbench;
    logic        sys_clk, rst, io_req, io_write, io_ack, io_hit, hit;
    logic [31:0] bar0_base, io_addr;
    logic [7:0]  io_wdata, io_rdata, write_data, rd, d;
    logic [63:0] receive_holding, interrupt_status_in, line_status_in;
    logic [63:0] modem_status_in;
    int          seed, mismatches, check_count;
    int          offs[4] = '{1, 3, 4, 7};

    io_host u_host (.sys_clk, .io_ack, .io_hit, .io_rdata, .io_req,
        .io_write, .io_addr, .io_wdata);
    uart_io_decode u_dut (.sys_clk, .rst, .bar0_base, .io_req, .io_write,
        .io_addr, .io_wdata, .io_ack, .io_hit, .io_rdata, .receive_holding,
        .interrupt_status_in, .line_status_in, .modem_status_in,
        .rx_read(), .tx_load(), .fifo_control_load(), .write_data,
        .interrupt_enable(), .line_control(), .modem_control(),
        .special_function(), .divisor_low(), .divisor_high(),
        .sample_clock_select());

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] byte_of(logic [63:0] v, int c);
        return v[c*8 +: 8];
    endfunction : byte_of

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, want);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic acc(input logic w, input int c, input int o,
                       input logic [7:0] wd);
        u_host.xfer(w, bar0_base + 32'(c * 8 + o), wd, rd, hit);
        if (u_host.timed_out) begin
            mismatches++;
            final_report();
        end
        chk({7'h00, hit}, {7'h00, ((c * 8 + o) inside {[0:63]})});
    endtask : acc

    initial begin
        seed = 32'h1429;
        mismatches = 0;
        check_count = 0;
        rst = 1'b1;
        bar0_base = ($random(seed) & 32'h7FFF_FF00) + 32'h0000_0100;
        receive_holding = {$random(seed), $random(seed)};
        interrupt_status_in = {8{8'hC1}};
        line_status_in = {$random(seed), $random(seed)};
        modem_status_in = {$random(seed), $random(seed)};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        for (int c = 0; c < 8; c++) begin
            acc(1'b0, c, 2, 8'h00);
            chk(rd, 8'hC1);
            foreach (offs[i]) begin
                d = $random(seed);
                // keep divisor access off while the plain map is walked
                d[7] = d[7] & (offs[i] != 3);
                acc(1'b1, c, offs[i], d);
                acc(1'b0, c, offs[i], 8'h00);
                chk(rd, d);
            end
            acc(1'b0, c, 0, 8'h00);
            chk(rd, byte_of(receive_holding, c));
            for (int o = 0; o < 3; o += 2) begin
                d = $random(seed);
                acc(1'b1, c, o, d);
                chk(write_data, d);
            end
            acc(1'b1, c, 3, 8'h80);
            for (int o = 0; o < 3; o++) begin
                d = $random(seed);
                acc(1'b1, c, o, d);
                acc(1'b0, c, o, 8'h00);
                chk(rd, d);
            end
            acc(1'b0, c, 3, 8'h00);
            chk(rd, 8'h80);
            acc(1'b1, c, 3, 8'h00);
            acc(1'b0, c, 2, 8'h00);
            chk(rd, 8'hC1);
            for (int o = 5; o < 7; o++) begin
                acc(1'b1, c, o, 8'hFF);
                acc(1'b0, c, o, 8'h00);
                d = byte_of(o == 5 ? line_status_in : modem_status_in, c);
                chk(rd, d);
            end
            $display("channel %0d map test done", c);
        end
        acc(1'b0, 8, 0, 8'h00);
        chk(rd, 8'h00);
        acc(1'b0, -1, 7, 8'h00);
        chk(rd, 8'h00);
        $display("window edge test done");
        final_report();
    end
endmodule : testbench
